// *** logic/flash_seq_pkg.sv ***
// Constants and types for the flash self-programming sequencer.
`default_nettype none
package flash_seq_pkg;
   // Register selectors on the processor's special-function register port.
   localparam logic [1:0] SEL_CONTROL = 2'h0;
   localparam logic [1:0] SEL_KEY = 2'h1;
   localparam logic [1:0] SEL_ADDR_HIGH = 2'h2;
   localparam logic [1:0] SEL_ADDR_LOW = 2'h3;
   // Control register fields.
   localparam int START_BIT = 15;
   localparam int ENABLE_BIT = 14;
   localparam int ERASE_BIT = 6;
   localparam logic [15:0] CONTROL_RESET = 16'h0000;
   localparam logic [7:0] ADDR_HIGH_RESET = 8'h00;
   localparam logic [15:0] ADDR_LOW_RESET = 16'h0000;
   localparam logic [15:0] RDATA_RESET = 16'h0000;
   localparam logic ALIGN_ERROR_RESET = 1'b0;
   localparam logic STROBE_RESET = 1'b0;
   // Unlock key values, written in this order.
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   // Word pairs start on every other word address: 0x000002, 0x000006, ...
   localparam logic [1:0] PAIR_ALIGN_MASK = 2'h3;
   localparam logic [1:0] PAIR_ALIGN_VALUE = 2'h2;
   // Unlock tracker states, Gray coded along the usual path.
   typedef enum logic [1:0]
   {
      KEY_IDLE = 2'b00,
      KEY_GOT_FIRST = 2'b01,
      KEY_ARMED = 2'b11
   } key_state_t;
   // Operation states, Gray coded along the usual path.
   typedef enum logic [1:0]
   {
      OP_IDLE = 2'b00,
      OP_ISSUE = 2'b01,
      OP_WAIT = 2'b11
   } op_state_t;
endpackage : flash_seq_pkg
`default_nettype wire

// *** logic/flash_self_program_sequencer.sv ***
// Run-time self-programming sequencer: unlock, start, stall and flash handshake.
`default_nettype none
module flash_self_program_sequencer
   import flash_seq_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic reset_n_i,
   // Processor register port.
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [1:0] reg_sel_i,
   input wire logic [15:0] reg_wdata_i,
   output logic [15:0] reg_rdata_o,
   // Processor stall.
   output logic cpu_stall_o,
   // Flash array command port.
   output logic flash_erase_o,
   output logic flash_program_o,
   output logic [23:0] effective_address_o,
   input wire logic flash_done_i,
   // Status.
   output logic align_error_o
);
   logic [15:0] flash_control_register;
   logic [7:0] flash_address_high_register;
   logic [15:0] flash_address_low_register;
   key_state_t key_state;
   op_state_t op_state;
   logic [15:0] rdata;
   logic align_error;
   logic [15:0] next_flash_control_register;
   logic [7:0] next_flash_address_high_register;
   logic [15:0] next_flash_address_low_register;
   key_state_t next_key_state;
   op_state_t next_op_state;
   logic [15:0] next_rdata;
   logic next_align_error;
   logic flash_erase;
   logic flash_program;
   logic next_flash_erase;
   logic next_flash_program;
   logic access;
   logic start_request;
   logic pair_aligned;
   logic [23:0] effective_address;
   // A stalled processor cannot issue accesses, so a strobe seen during an operation is stray;
   // it neither advances nor breaks the unlock, just as the registers ignore it.
   assign access = (reg_write_i | reg_read_i) && op_state == OP_IDLE;
   assign effective_address = {flash_address_high_register,
                               flash_address_low_register};
   // Only the pair boundary is checked; whether the address exists is the array's concern.
   assign pair_aligned = (effective_address[1:0] & PAIR_ALIGN_MASK)
                         == PAIR_ALIGN_VALUE;
   assign start_request = reg_write_i && reg_sel_i == SEL_CONTROL
                          && reg_wdata_i[START_BIT] && reg_wdata_i[ENABLE_BIT];

   // Unlock tracker: the armed state lasts only until the very next access.
   always_comb
   begin
      next_key_state = key_state;
      if (access)
      begin
         next_key_state = KEY_IDLE;
         if (reg_write_i && reg_sel_i == SEL_KEY)
         begin
            case (key_state)
               KEY_IDLE:
                  next_key_state = (reg_wdata_i[7:0] == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
               KEY_GOT_FIRST:
               begin
                  if (reg_wdata_i[7:0] == KEY_SECOND)
                     next_key_state = KEY_ARMED;
                  // A repeated first key restarts the unlock, so a retried sequence still works.
                  else if (reg_wdata_i[7:0] == KEY_FIRST)
                     next_key_state = KEY_GOT_FIRST;
                  else
                     next_key_state = KEY_IDLE;
               end
               KEY_ARMED:
                  next_key_state = (reg_wdata_i[7:0] == KEY_FIRST) ? KEY_GOT_FIRST : KEY_IDLE;
               default:
                  next_key_state = KEY_IDLE;
            endcase
         end
      end
   end

   // Unlock tracker register.
   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
         key_state <= KEY_IDLE;
      else
         key_state <= next_key_state;
   end

   // Registers and the operation sequencer.
   always_comb
   begin
      next_flash_control_register = flash_control_register;
      next_flash_address_high_register = flash_address_high_register;
      next_flash_address_low_register = flash_address_low_register;
      next_op_state = op_state;
      next_rdata = rdata;
      next_align_error = align_error;
      case (op_state)
         OP_IDLE:
         begin
            if (reg_write_i)
            begin
               case (reg_sel_i)
                  SEL_CONTROL:
                  begin
                     // Start is only latched here; it is never taken from a plain write.
                     next_flash_control_register = reg_wdata_i;
                     next_flash_control_register[START_BIT] = 1'b0;
                     if (start_request && key_state == KEY_ARMED)
                     begin
                        if (reg_wdata_i[ERASE_BIT] || pair_aligned)
                        begin
                           next_flash_control_register[START_BIT] = 1'b1;
                           next_op_state = OP_ISSUE;
                           next_align_error = 1'b0;
                        end
                        else
                        begin
                           // Refused rather than rounded down, so no wrong pair is programmed.
                           next_align_error = 1'b1;
                        end
                     end
                  end
                  SEL_ADDR_HIGH:
                     next_flash_address_high_register = reg_wdata_i[7:0];
                  SEL_ADDR_LOW:
                     next_flash_address_low_register = reg_wdata_i;
                  default:
                     next_rdata = rdata;
               endcase
            end
            if (reg_read_i)
            begin
               case (reg_sel_i)
                  SEL_CONTROL:
                     next_rdata = flash_control_register;
                  SEL_ADDR_HIGH:
                     next_rdata = {8'h00, flash_address_high_register};
                  SEL_ADDR_LOW:
                     next_rdata = flash_address_low_register;
                  default:
                     next_rdata = 16'h0000;
               endcase
            end
         end
         // The array cannot finish in the cycle it is started, so done is heeded only in the wait.
         OP_ISSUE:
            next_op_state = OP_WAIT;
         OP_WAIT:
         begin
            if (flash_done_i)
            begin
               // Start clears in the cycle that the stall drops, so resumed code never sees it set.
               next_flash_control_register[START_BIT] = 1'b0;
               next_op_state = OP_IDLE;
            end
         end
         default:
            next_op_state = OP_IDLE;
      endcase
      // The array strobes come from flip-flops so that it sees one clean cycle, free of decode
      // glitches.
      next_flash_erase = next_op_state == OP_ISSUE && next_flash_control_register[ERASE_BIT];
      next_flash_program = next_op_state == OP_ISSUE && !next_flash_control_register[ERASE_BIT];
   end

   always_ff @(posedge clk_i)
   begin
      if (!reset_n_i)
      begin
         op_state <= OP_IDLE;
         flash_control_register <= CONTROL_RESET;
         flash_address_high_register <= ADDR_HIGH_RESET;
         flash_address_low_register <= ADDR_LOW_RESET;
         rdata <= RDATA_RESET;
         align_error <= ALIGN_ERROR_RESET;
         flash_erase <= STROBE_RESET;
         flash_program <= STROBE_RESET;
      end
      else
      begin
         op_state <= next_op_state;
         flash_control_register <= next_flash_control_register;
         flash_address_high_register <= next_flash_address_high_register;
         flash_address_low_register <= next_flash_address_low_register;
         rdata <= next_rdata;
         align_error <= next_align_error;
         flash_erase <= next_flash_erase;
         flash_program <= next_flash_program;
      end
   end

   // The processor cannot touch the registers while stalled, so they stay stable.
   assign cpu_stall_o = op_state != OP_IDLE;
   assign flash_erase_o = flash_erase;
   assign flash_program_o = flash_program;
   assign effective_address_o = effective_address;
   assign reg_rdata_o = rdata;
   assign align_error_o = align_error;
endmodule : flash_self_program_sequencer
`default_nettype wire

// *** dv/flash_seq_monitor.sv ***
// Port assertions for the flash self-programming sequencer.
`default_nettype none
module flash_seq_monitor
   import flash_seq_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic reg_write_i,
   input wire logic reg_read_i,
   input wire logic [1:0] reg_sel_i,
   input wire logic [15:0] reg_wdata_i,
   input wire logic [15:0] reg_rdata_o,
   input wire logic cpu_stall_o,
   input wire logic flash_erase_o,
   input wire logic flash_program_o,
   input wire logic [23:0] effective_address_o,
   input wire logic flash_done_i,
   input wire logic align_error_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   logic acc, wkey, go, armed_go, k1, k2, next_k1, next_k2;
   assign acc = (reg_write_i || reg_read_i) && !cpu_stall_o;
   assign wkey = acc && reg_write_i && reg_sel_i == SEL_KEY;
   assign go = acc && reg_write_i && reg_sel_i == SEL_CONTROL && reg_wdata_i[START_BIT];
   assign armed_go = go && reg_wdata_i[ENABLE_BIT] && k2;
   // Any accepted access ends a partial unlock, so both flags follow every access.
   always_comb
   begin
      next_k1 = acc ? wkey && reg_wdata_i[7:0] == KEY_FIRST : k1;
      next_k2 = acc ? wkey && reg_wdata_i[7:0] == KEY_SECOND && k1 : k2;
   end
   always_ff @(posedge clk_i)
   begin
      k1 <= reset_n_i && next_k1;
      k2 <= reset_n_i && next_k2;
   end
   a_launch_needs_unlock: assert property ($rose(cpu_stall_o) |-> $past(armed_go))
      else $error("operation launched without a full unlock");
   a_unlock_launches: assert property (armed_go && (reg_wdata_i[ERASE_BIT] ||
      effective_address_o[1:0] == PAIR_ALIGN_VALUE) |=> cpu_stall_o && flash_erase_o ==
      $past(reg_wdata_i[ERASE_BIT]) && flash_program_o != flash_erase_o)
      else $error("armed start did not launch the chosen operation");
   a_misalign_refused: assert property (armed_go && !reg_wdata_i[ERASE_BIT] &&
      effective_address_o[1:0] != PAIR_ALIGN_VALUE |=> !cpu_stall_o && align_error_o)
      else $error("misaligned program was not refused");
   a_pulse_once: assert property ((flash_erase_o || flash_program_o) |->
      cpu_stall_o ##1 !(flash_erase_o || flash_program_o))
      else $error("flash command pulse is wrong");
   a_done_releases: assert property (cpu_stall_o && !flash_erase_o &&
      !flash_program_o && flash_done_i |=> !cpu_stall_o)
      else $error("stall not released after done");
   a_stall_until_done: assert property (cpu_stall_o && !flash_done_i |=> cpu_stall_o)
      else $error("stall dropped before done");
   a_key_reads_zero: assert property (acc && reg_read_i &&
      reg_sel_i == SEL_KEY |=> reg_rdata_o == 16'h0000)
      else $error("key register read returned data");
   a_ea_high_byte: assert property (acc && reg_write_i &&
      reg_sel_i == SEL_ADDR_HIGH |=> effective_address_o[23:16] == $past(reg_wdata_i[7:0]))
      else $error("high address byte not in place");
   cover property (flash_erase_o);
   cover property (flash_program_o);
   cover property (align_error_o);
endmodule : flash_seq_monitor
bind flash_self_program_sequencer flash_seq_monitor u_mon (.clk_i, .reset_n_i, .reg_write_i,
   .reg_read_i, .reg_sel_i, .reg_wdata_i, .reg_rdata_o, .cpu_stall_o, .flash_erase_o,
   .flash_program_o, .effective_address_o, .flash_done_i, .align_error_o);
`default_nettype wire

// *** dv/tb_top.sv ***
// Self-checking bench for the flash self-programming sequencer.
`default_nettype none
module tb_top import flash_seq_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic reg_write_i = 1'b0;
   logic reg_read_i = 1'b0;
   logic [1:0] reg_sel_i = 2'h0;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic flash_done_i = 1'b0;
   logic [15:0] reg_rdata_o;
   logic cpu_stall_o, flash_erase_o, flash_program_o, align_error_o;
   logic [23:0] effective_address_o;
   int fails = 0;
   int n_compared = 0;
   always #2.5 clk_i = ~clk_i;
   flash_self_program_sequencer u_dut (.clk_i, .reset_n_i, .reg_write_i, .reg_read_i,
      .reg_sel_i, .reg_wdata_i, .reg_rdata_o, .cpu_stall_o, .flash_erase_o, .flash_program_o,
      .effective_address_o, .flash_done_i, .align_error_o);
   // Counts the comparison and holds only on a clean one, so an unknown never passes.
   function automatic bit seen(input logic c);
      n_compared++;
      return c === 1'b1;
   endfunction : seen
   task automatic mismatch(input string m);
      fails++;
      $display("[FAIL] %0t %s", $time, m);
   endtask : mismatch
   // Leaves the strobe up so back-to-back accesses never touch it twice in one step.
   task automatic acc(input logic w, input logic [1:0] s, input logic [15:0] d);
      reg_write_i = w;
      reg_read_i = !w;
      reg_sel_i = s;
      reg_wdata_i = d;
      @(negedge clk_i);
   endtask : acc
   task automatic op(input logic er, input logic [23:0] ea, input logic brk, input logic ok);
      logic [2:0] ne;
      logic [2:0] np;
      ne = 3'h0;
      np = 3'h0;
      acc(1'b1, SEL_ADDR_HIGH, {8'h00, ea[23:16]});
      acc(1'b1, SEL_ADDR_LOW, ea[15:0]);
      acc(1'b1, SEL_KEY, 16'h0055);
      if (brk) acc(1'b0, SEL_KEY, 16'h0000);
      acc(1'b1, SEL_KEY, 16'h00aa);
      acc(1'b1, SEL_CONTROL, {9'h180, er, 6'h00});
      // The idle cycles after the start write stand in for the two no-operations after it.
      reg_write_i = 1'b0;
      repeat (4)
      begin
         ne = ne + {2'h0, flash_erase_o};
         np = np + {2'h0, flash_program_o};
         @(negedge clk_i);
      end
      if (!seen(ne === {2'h0, ok & er} && np === {2'h0, ok & !er}))
         mismatch("launch pulse");
      if (!seen(cpu_stall_o === ok)) mismatch("stall level");
      if (!seen(effective_address_o === ea)) mismatch("address");
      if (!brk && !seen(align_error_o === (!er && ea[1:0] != 2'h2)))
         mismatch("alignment");
      // The bench stands in for the array and answers after the four idle cycles, whether or not an operation began.
      flash_done_i = 1'b1;
      @(negedge clk_i);
      flash_done_i = 1'b0;
      if (!seen(cpu_stall_o === 1'b0)) mismatch("release");
      acc(1'b0, SEL_CONTROL, 16'h0000);
      reg_read_i = 1'b0;
      if (!seen(reg_rdata_o[START_BIT] === 1'b0)) mismatch("start bit");
      if (!seen(reg_rdata_o === {2'h1, 7'h00, er, 6'h00}))
         mismatch("control readback");
      @(negedge clk_i);
      $display("operation test done at %h", ea);
   endtask : op
   task automatic key_test();
      if (!seen(cpu_stall_o === 1'b0 && effective_address_o === 24'h000000))
         mismatch("reset state");
      acc(1'b1, SEL_ADDR_LOW, 16'h5a5a);
      acc(1'b0, SEL_ADDR_LOW, 16'h0000);
      if (!seen(reg_rdata_o === 16'h5a5a)) mismatch("address readback");
      acc(1'b1, SEL_KEY, 16'h0055);
      acc(1'b0, SEL_KEY, 16'h0000);
      reg_read_i = 1'b0;
      if (!seen(reg_rdata_o === 16'h0000)) mismatch("key read");
      @(negedge clk_i);
      $display("reset and key test done");
   endtask : key_test
   task automatic give_verdict();
      $display("compared %0d, failed %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (17) @(negedge clk_i);
      reset_n_i = 1'b1;
      @(negedge clk_i);
      key_test();
      op(1'b1, 24'h000100, 1'b0, 1'b1);
      op(1'b0, 24'h000106, 1'b0, 1'b1);
      op(1'b0, 24'h000104, 1'b0, 1'b0);
      op(1'b0, 24'h123456, 1'b1, 1'b0);
      op(1'b0, 24'h123456, 1'b0, 1'b1);
      give_verdict();
   end
   // The whole sequence takes about 84 cycles.
   initial
   begin
      #5000;
      fails++;
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
